// file: shared/fqt_pkg.sv
// Purpose: Constants and types shared by the flash query responder
// Assumes: 16-bit flash bus, word addresses A21-A1 as addr[20:0]
// Notes: Command codes are chosen values, see parameters below
package fqt_pkg;
  localparam int ADDR_W = 21;
  localparam int DATA_W = 16;
  localparam int BLK_W = 5;
  localparam int BLOCKS = 32;
  localparam int BLK_LSB = 16;

  // Host command codes taken on the low data byte
  localparam logic [7:0] CMD_QUERY_ENTRY = 8'h98;
  localparam logic [7:0] CMD_READ_ARRAY = 8'hff;

  // Query offsets (word addresses)
  localparam logic [20:0] OFS_PTR_LO = 21'h00_0015;
  localparam logic [20:0] OFS_PTR_HI = 21'h00_0016;
  localparam logic [20:0] OFS_SIZE = 21'h00_0027;
  localparam logic [20:0] OFS_WBUF_LO = 21'h00_002a;
  localparam logic [20:0] OFS_WBUF_HI = 21'h00_002b;
  localparam logic [20:0] OFS_REGIONS = 21'h00_002c;
  localparam logic [20:0] OFS_NBLK_LO = 21'h00_002d;
  localparam logic [20:0] OFS_NBLK_HI = 21'h00_002e;
  localparam logic [20:0] OFS_BSZ_LO = 21'h00_002f;
  localparam logic [20:0] OFS_BSZ_HI = 21'h00_0030;
  localparam logic [15:0] OFS_BLK_STATUS = 16'h0002;

  // Query data bytes
  localparam logic [7:0] VAL_PTR = 8'h31;
  localparam logic [7:0] VAL_SIZE = 8'h16;
  localparam logic [7:0] VAL_WBUF = 8'h05;
  localparam logic [7:0] VAL_REGIONS = 8'h01;
  localparam logic [7:0] VAL_NBLK = 8'h1f;
  localparam logic [7:0] VAL_BSZ = 8'h02;
  localparam logic [7:0] VAL_SIG_P = 8'h50;
  localparam logic [7:0] VAL_SIG_R = 8'h52;
  localparam logic [7:0] VAL_SIG_I = 8'h49;
  localparam logic [7:0] VAL_FEAT_LO = 8'hce;
  localparam logic [7:0] VAL_FEAT_HI = 8'h01;
  localparam logic [7:0] VAL_SUSP = 8'h01;
  localparam logic [7:0] VAL_BSR_ACT = 8'h01;
  localparam logic [7:0] VAL_OTP_FIELDS = 8'h01;
  localparam logic [7:0] VAL_OTP_ADDR_LO = 8'h80;
  localparam logic [7:0] VAL_OTP_LOG2 = 8'h03;
  localparam logic [7:0] VAL_PAGE_LOG2 = 8'h03;
  localparam logic [7:0] VAL_SYNC_FIELDS = 8'h03;
  localparam logic [20:0] PRI_BASE = 21'h00_0031;

  // Reset values
  localparam logic [15:0] DQ_RESET = 16'h0000;
  localparam logic [7:0] CMD_RESET = 8'h00;

  typedef enum logic {FQT_MODE_ARRAY, FQT_MODE_QUERY} fqt_mode_t;

  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic [20:0] addr;
    logic [15:0] dq;
  } fqt_bus_t;
endpackage

// file: rtl/fqt_sync.sv
// Purpose: Two-flop synchroniser for the flash bus pins
// Assumes: Pins are asynchronous to clock
// Notes: First stage feeds only the second stage
module fqt_sync #(
  parameter int W = 40,
  parameter logic [W-1:0] RST_VAL = '1
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      meta_r <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule

// file: rtl/fqt_query_rom.sv
// Purpose: Fixed query table lookup by word address
// Assumes: Address already synchronised
// Notes: Unlisted offsets give zero
module fqt_query_rom (
  input wire logic [20:0] addr,
  output logic [7:0] qbyte
);
  function automatic logic [7:0] lookup(input logic [20:0] a);
    logic [7:0] v;
    v = 8'h00;
    unique case (a)
      fqt_pkg::OFS_PTR_LO: v = fqt_pkg::VAL_PTR;
      fqt_pkg::OFS_SIZE: v = fqt_pkg::VAL_SIZE;
      fqt_pkg::OFS_WBUF_LO: v = fqt_pkg::VAL_WBUF;
      fqt_pkg::OFS_REGIONS: v = fqt_pkg::VAL_REGIONS;
      fqt_pkg::OFS_NBLK_LO: v = fqt_pkg::VAL_NBLK;
      fqt_pkg::OFS_BSZ_HI: v = fqt_pkg::VAL_BSZ;
      fqt_pkg::PRI_BASE: v = fqt_pkg::VAL_SIG_P;
      fqt_pkg::PRI_BASE + 21'h1: v = fqt_pkg::VAL_SIG_R;
      fqt_pkg::PRI_BASE + 21'h2: v = fqt_pkg::VAL_SIG_I;
      fqt_pkg::PRI_BASE + 21'h5: v = fqt_pkg::VAL_FEAT_LO;
      fqt_pkg::PRI_BASE + 21'h6: v = fqt_pkg::VAL_FEAT_HI;
      fqt_pkg::PRI_BASE + 21'h9: v = fqt_pkg::VAL_SUSP;
      fqt_pkg::PRI_BASE + 21'ha: v = fqt_pkg::VAL_BSR_ACT;
      fqt_pkg::PRI_BASE + 21'he: v = fqt_pkg::VAL_OTP_FIELDS;
      fqt_pkg::PRI_BASE + 21'hf: v = fqt_pkg::VAL_OTP_ADDR_LO;
      fqt_pkg::PRI_BASE + 21'h11: v = fqt_pkg::VAL_OTP_LOG2;
      fqt_pkg::PRI_BASE + 21'h12: v = fqt_pkg::VAL_OTP_LOG2;
      fqt_pkg::PRI_BASE + 21'h13: v = fqt_pkg::VAL_PAGE_LOG2;
      fqt_pkg::PRI_BASE + 21'h14: v = fqt_pkg::VAL_SYNC_FIELDS;
      // Listed zero words and unlisted offsets
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  always_comb begin
    qbyte = lookup(addr);
  end
endmodule

// file: rtl/fqt_responder.sv
// Purpose: Query-mode read responder of a 16-bit flash device
// Assumes: Host drives ce_n, oe_n, we_n, addr, dq asynchronously
// Notes: Array contents and protection state come from neighbouring logic
module fqt_responder (
  input wire logic clock,
  input wire logic rst,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic [20:0] addr,
  input wire logic [15:0] dq_i,
  output logic [15:0] dq_o,
  output logic dq_oe,
  input wire logic [31:0] block_protected,
  input wire logic [15:0] array_rdata,
  output logic [20:0] array_addr,
  output logic query_mode
);
  fqt_pkg::fqt_bus_t bus_raw;
  fqt_pkg::fqt_bus_t bus_s;
  fqt_pkg::fqt_mode_t mode_r;
  logic rd_act;
  logic we_act;
  logic we_prev_r;
  logic wr_end;
  logic [7:0] cmd_r;
  logic [7:0] rom_byte;
  logic [7:0] status_byte;
  logic [7:0] query_byte;
  logic blk_status_hit;
  logic [4:0] blk_sel;
  logic [15:0] dq_nxt;
  logic [15:0] dq_o_r;
  logic dq_oe_r;

  always_comb begin
    bus_raw.ce_n = ce_n;
    bus_raw.oe_n = oe_n;
    bus_raw.we_n = we_n;
    bus_raw.addr = addr;
    bus_raw.dq = dq_i;
  end

  // Idle bus after reset: strobes high
  fqt_sync #(
    .W($bits(fqt_pkg::fqt_bus_t)),
    .RST_VAL({$bits(fqt_pkg::fqt_bus_t){1'b1}})
  ) u_sync (
    .clock(clock),
    .rst(rst),
    .d(bus_raw),
    .q(bus_s)
  );

  fqt_query_rom u_rom (
    .addr(bus_s.addr),
    .qbyte(rom_byte)
  );

  assign rd_act = !bus_s.ce_n && !bus_s.oe_n && bus_s.we_n;
  assign we_act = !bus_s.ce_n && !bus_s.we_n;
  assign wr_end = we_prev_r && !we_act;

  // Command byte held from the last cycle of the write strobe
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cmd_r <= fqt_pkg::CMD_RESET;
    end else if (we_act) begin
      cmd_r <= bus_s.dq[7:0];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      we_prev_r <= 1'b0;
    end else begin
      we_prev_r <= we_act;
    end
  end

  // Mode switch at the end of each write; other codes are ignored here
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mode_r <= fqt_pkg::FQT_MODE_ARRAY;
    end else if (wr_end) begin
      if (cmd_r == fqt_pkg::CMD_QUERY_ENTRY) begin
        mode_r <= fqt_pkg::FQT_MODE_QUERY;
      end else if (cmd_r == fqt_pkg::CMD_READ_ARRAY) begin
        mode_r <= fqt_pkg::FQT_MODE_ARRAY;
      end
    end
  end

  // Block status word at offset two of every block
  assign blk_sel = bus_s.addr[20:fqt_pkg::BLK_LSB];
  assign blk_status_hit = bus_s.addr[15:0] == fqt_pkg::OFS_BLK_STATUS;

  always_comb begin
    status_byte = 8'h00;
    status_byte[0] = block_protected[blk_sel];
  end

  assign query_byte = blk_status_hit ? status_byte : rom_byte;

  always_comb begin
    if (mode_r == fqt_pkg::FQT_MODE_QUERY) begin
      dq_nxt = {8'h00, query_byte};
    end else begin
      dq_nxt = array_rdata;
    end
  end

  // Data held between reads so a slow host sees a stable word
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dq_o_r <= fqt_pkg::DQ_RESET;
    end else if (rd_act) begin
      dq_o_r <= dq_nxt;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dq_oe_r <= 1'b0;
    end else begin
      dq_oe_r <= rd_act;
    end
  end

  assign dq_o = dq_o_r;
  assign dq_oe = dq_oe_r;
  // Same address as the read, so the array word and the strobe line up
  assign array_addr = bus_s.addr;
  assign query_mode = mode_r == fqt_pkg::FQT_MODE_QUERY;

  // Checks on the read path and mode control
  logic q_rd;
  assign q_rd = rd_act && mode_r == fqt_pkg::FQT_MODE_QUERY;

  a_geom_size: assert property (
    @(posedge clock) disable iff (rst)
    q_rd && bus_s.addr == fqt_pkg::OFS_SIZE
    |=> dq_o == {8'h00, fqt_pkg::VAL_SIZE} && dq_oe
  ) else $error("memory size word wrong");

  a_wbuf_pair: assert property (
    @(posedge clock) disable iff (rst)
    q_rd && (bus_s.addr == fqt_pkg::OFS_WBUF_LO || bus_s.addr == fqt_pkg::OFS_WBUF_HI)
    |=> dq_o == ($past(bus_s.addr) == fqt_pkg::OFS_WBUF_LO ?
                 {8'h00, fqt_pkg::VAL_WBUF} : 16'h0000)
  ) else $error("write buffer size word wrong");

  a_region_count: assert property (
    @(posedge clock) disable iff (rst)
    q_rd && bus_s.addr == fqt_pkg::OFS_REGIONS
    |=> dq_o == {8'h00, fqt_pkg::VAL_REGIONS}
  ) else $error("erase region count wrong");

  a_block_count: assert property (
    @(posedge clock) disable iff (rst)
    q_rd && (bus_s.addr == fqt_pkg::OFS_NBLK_LO || bus_s.addr == fqt_pkg::OFS_NBLK_HI)
    |=> dq_o == ($past(bus_s.addr) == fqt_pkg::OFS_NBLK_LO ?
                 {8'h00, fqt_pkg::VAL_NBLK} : 16'h0000)
  ) else $error("erase block count wrong");

  a_block_size: assert property (
    @(posedge clock) disable iff (rst)
    q_rd && (bus_s.addr == fqt_pkg::OFS_BSZ_LO || bus_s.addr == fqt_pkg::OFS_BSZ_HI)
    |=> dq_o == ($past(bus_s.addr) == fqt_pkg::OFS_BSZ_HI ?
                 {8'h00, fqt_pkg::VAL_BSZ} : 16'h0000)
  ) else $error("erase block size wrong");

  a_blk_protect: assert property (
    @(posedge clock) disable iff (rst)
    q_rd && bus_s.addr[15:0] == fqt_pkg::OFS_BLK_STATUS
    |=> dq_o[0] == $past(block_protected[bus_s.addr[20:16]]) && dq_o[1] == 1'b0
  ) else $error("block protect bit wrong");

  a_blk_reserved: assert property (
    @(posedge clock) disable iff (rst)
    q_rd && blk_status_hit |=> dq_o[15:2] == 14'h0000
  ) else $error("block status reserved bits set");

  a_blk_select: assert property (
    @(posedge clock) disable iff (rst)
    q_rd && blk_status_hit && block_protected[blk_sel] |=> dq_o == 16'h0001
  ) else $error("block status not at base plus two");

  a_sig_string: assert property (
    @(posedge clock) disable iff (rst)
    q_rd && bus_s.addr == fqt_pkg::PRI_BASE + 21'h2 |=> dq_o[7:0] == fqt_pkg::VAL_SIG_I
  ) else $error("extended table signature wrong");

  a_sig_first: assert property (
    @(posedge clock) disable iff (rst)
    q_rd && bus_s.addr == fqt_pkg::PRI_BASE |=> dq_o == {8'h00, fqt_pkg::VAL_SIG_P}
  ) else $error("extended table first letter wrong");

  a_sig_second: assert property (
    @(posedge clock) disable iff (rst)
    q_rd && bus_s.addr == fqt_pkg::PRI_BASE + 21'h1 |=> dq_o == {8'h00, fqt_pkg::VAL_SIG_R}
  ) else $error("extended table second letter wrong");

  a_feat_low: assert property (
    @(posedge clock) disable iff (rst)
    q_rd && bus_s.addr == fqt_pkg::PRI_BASE + 21'h5 |=> dq_o == {8'h00, fqt_pkg::VAL_FEAT_LO}
  ) else $error("optional feature byte wrong");

  a_feat_high: assert property (
    @(posedge clock) disable iff (rst)
    q_rd && (bus_s.addr == fqt_pkg::PRI_BASE + 21'h6 || bus_s.addr == fqt_pkg::PRI_BASE + 21'h7)
    |=> dq_o == ($past(bus_s.addr) == fqt_pkg::PRI_BASE + 21'h6 ?
                 {8'h00, fqt_pkg::VAL_FEAT_HI} : 16'h0000)
  ) else $error("optional feature upper bytes wrong");

  a_susp_word: assert property (
    @(posedge clock) disable iff (rst)
    q_rd && bus_s.addr == fqt_pkg::PRI_BASE + 21'h9 |=> dq_o == {8'h00, fqt_pkg::VAL_SUSP}
  ) else $error("suspend function word wrong");

  a_bsr_active: assert property (
    @(posedge clock) disable iff (rst)
    q_rd && (bus_s.addr == fqt_pkg::PRI_BASE + 21'ha || bus_s.addr == fqt_pkg::PRI_BASE + 21'hb)
    |=> dq_o == ($past(bus_s.addr) == fqt_pkg::PRI_BASE + 21'ha ?
                 {8'h00, fqt_pkg::VAL_BSR_ACT} : 16'h0000)
  ) else $error("status register support words wrong");

  a_otp_addr: assert property (
    @(posedge clock) disable iff (rst)
    q_rd && bus_s.addr == fqt_pkg::PRI_BASE + 21'hf |=> dq_o[7:0] == fqt_pkg::VAL_OTP_ADDR_LO
  ) else $error("protection register address wrong");

  a_otp_fields: assert property (
    @(posedge clock) disable iff (rst)
    q_rd && bus_s.addr == fqt_pkg::PRI_BASE + 21'he |=> dq_o == {8'h00, fqt_pkg::VAL_OTP_FIELDS}
  ) else $error("protection register field count wrong");

  a_otp_addr_hi: assert property (
    @(posedge clock) disable iff (rst)
    q_rd && bus_s.addr == fqt_pkg::PRI_BASE + 21'h10 |=> dq_o == 16'h0000
  ) else $error("protection register address high byte wrong");

  a_otp_size: assert property (
    @(posedge clock) disable iff (rst)
    q_rd && (bus_s.addr == fqt_pkg::PRI_BASE + 21'h11 || bus_s.addr == fqt_pkg::PRI_BASE + 21'h12)
    |=> dq_o == {8'h00, fqt_pkg::VAL_OTP_LOG2}
  ) else $error("protection byte count wrong");

  a_page_sync: assert property (
    @(posedge clock) disable iff (rst)
    q_rd && bus_s.addr == fqt_pkg::PRI_BASE + 21'h13 |=> dq_o == {8'h00, fqt_pkg::VAL_PAGE_LOG2}
  ) else $error("page size word wrong");

  a_sync_fields: assert property (
    @(posedge clock) disable iff (rst)
    q_rd && bus_s.addr == fqt_pkg::PRI_BASE + 21'h14 |=> dq_o == {8'h00, fqt_pkg::VAL_SYNC_FIELDS}
  ) else $error("sync field count wrong");

  a_high_zero: assert property (
    @(posedge clock) disable iff (rst)
    q_rd |=> dq_oe && dq_o[15:8] == 8'h00
  ) else $error("query word drives upper byte");

  a_pointer: assert property (
    @(posedge clock) disable iff (rst)
    q_rd && bus_s.addr == fqt_pkg::OFS_PTR_LO |=> dq_o == {8'h00, fqt_pkg::VAL_PTR}
  ) else $error("table pointer wrong");

  a_ptr_full: assert property (
    @(posedge clock) disable iff (rst)
    q_rd && bus_s.addr == fqt_pkg::OFS_PTR_HI |=> dq_o == 16'h0000
  ) else $error("table pointer upper word wrong");

  a_query_entry: assert property (
    @(posedge clock) disable iff (rst)
    wr_end && cmd_r == fqt_pkg::CMD_QUERY_ENTRY |=> query_mode
  ) else $error("query entry not taken");

  a_mode_hold: assert property (
    @(posedge clock) disable iff (rst)
    !wr_end |=> $stable(mode_r)
  ) else $error("mode changed without a command");

  a_array_read: assert property (
    @(posedge clock) disable iff (rst)
    rd_act && !query_mode |=> dq_oe && dq_o == $past(array_rdata)
  ) else $error("array word not served outside query mode");

  a_array_exit: assert property (
    @(posedge clock) disable iff (rst)
    wr_end && cmd_r == fqt_pkg::CMD_READ_ARRAY |=> !query_mode
  ) else $error("read array did not leave query mode");

  a_unlisted_zero: assert property (
    @(posedge clock) disable iff (rst)
    q_rd && bus_s.addr > fqt_pkg::PRI_BASE + 21'h14 && !blk_status_hit |=> dq_o == 16'h0000
  ) else $error("unlisted query offset not zero");

  c_query_read: cover property (
    @(posedge clock) disable iff (rst)
    q_rd && bus_s.addr == fqt_pkg::OFS_SIZE ##1 dq_oe
  );

  c_blk_protected: cover property (
    @(posedge clock) disable iff (rst)
    q_rd && blk_status_hit && block_protected[blk_sel]
  );

  c_mode_entry: cover property (
    @(posedge clock) disable iff (rst)
    !query_mode ##1 query_mode
  );

  c_mode_exit: cover property (
    @(posedge clock) disable iff (rst)
    query_mode ##1 !query_mode
  );

  c_array_read: cover property (
    @(posedge clock) disable iff (rst)
    rd_act && !query_mode ##1 dq_oe
  );
endmodule

// file: tb/fqt_host.sv
// Purpose: Host flash controller model that drives the responder pins
// Assumes: Pins change 1 ns after a rising clock edge
// Notes: Data pins released by both sides show the inverse of the last word the host drove
module fqt_host (
  input wire logic clock,
  output logic ce_n,
  output logic oe_n,
  output logic we_n,
  output logic [20:0] addr,
  output logic [15:0] dq_i,
  input wire logic [15:0] dq_o,
  input wire logic dq_oe
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [15:0] drv_r = 16'h0000;
  logic drv_oe_r = 1'b0;

  // Wire level from both parties, no pull on the data lines
  assign dq_i = drv_oe_r ? drv_r : (dq_oe ? dq_o : ~drv_r);

  initial begin
    ce_n = 1'b1;
    oe_n = 1'b1;
    we_n = 1'b1;
    addr = 21'h00_0000;
  end

  task automatic step();
    @(posedge clock);
    #1;
  endtask

  // Command write, strobe held 4 clocks, then 5 clocks idle
  task automatic bus_write(input logic [7:0] cmd);
    step();
    ce_n = 1'b0;
    we_n = 1'b0;
    drv_r = {8'h00, cmd};
    drv_oe_r = 1'b1;
    repeat (4) step();
    ce_n = 1'b1;
    we_n = 1'b1;
    step();
    drv_oe_r = 1'b0;
    repeat (4) step();
  endtask

  // Read held until the drive enable is seen, then released
  task automatic bus_read(input logic [20:0] a, output logic [15:0] d);
    int n;
    d = 'x;
    step();
    addr = a;
    ce_n = 1'b0;
    oe_n = 1'b0;
    n = 0;
    while (dq_oe !== 1'b1 && n < 10) begin
      step();
      n++;
    end
    if (dq_oe === 1'b1) begin
      d = dq_o;
    end
    ce_n = 1'b1;
    oe_n = 1'b1;
    n = 0;
    while (dq_oe !== 1'b0 && n < 10) begin
      step();
      n++;
    end
  endtask
endmodule

// file: tb/test_flash_query_table_responder.sv
// Purpose: Self-checking bench for the flash query responder
// Assumes: Host model issues all bus cycles, array data is a fixed pattern
// Notes: Query table entries hold offset in the high byte, data in the low byte
module test_flash_query_table_responder;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int CEIL = 6000;

  logic clock;
  logic rst;
  logic ce_n;
  logic oe_n;
  logic we_n;
  logic [20:0] addr;
  logic [20:0] array_addr;
  logic [15:0] dq_i;
  logic [15:0] dq_o;
  logic [15:0] array_rdata;
  logic [15:0] rd;
  logic dq_oe;
  logic query_mode;
  logic [31:0] block_protected = 32'ha5c3_0f96;
  int num_errors = 0;
  int n_checks = 0;
  int cycles = 0;
  logic [15:0] tbl [27] = '{
    16'h1531, 16'h1600, 16'h2716, 16'h2a05, 16'h2b00, 16'h2c01, 16'h2d1f,
    16'h2e00, 16'h2f00, 16'h3002, 16'h3150, 16'h3252, 16'h3349, 16'h36ce,
    16'h3701, 16'h3800, 16'h3900, 16'h3a01, 16'h3b01, 16'h3c00, 16'h3f01,
    16'h4080, 16'h4100, 16'h4203, 16'h4303, 16'h4403, 16'h4503
  };

  // Array contents seen outside query mode
  assign array_rdata = array_addr[15:0] ^ 16'h5a5a;

  fqt_responder dut_u (
    .clock(clock),
    .rst(rst),
    .ce_n(ce_n),
    .oe_n(oe_n),
    .we_n(we_n),
    .addr(addr),
    .dq_i(dq_i),
    .dq_o(dq_o),
    .dq_oe(dq_oe),
    .block_protected(block_protected),
    .array_rdata(array_rdata),
    .array_addr(array_addr),
    .query_mode(query_mode)
  );

  fqt_host host_u (
    .clock(clock),
    .ce_n(ce_n),
    .oe_n(oe_n),
    .we_n(we_n),
    .addr(addr),
    .dq_i(dq_i),
    .dq_o(dq_o),
    .dq_oe(dq_oe)
  );

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run();
    if (num_errors == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == CEIL) begin
      num_errors++;
      complete_run();
    end
  end

  initial begin
    rst = 1'b1;
    repeat (8) @(posedge clock);
    #1;
    rst = 1'b0;
    repeat (2) @(posedge clock);
    #1;
    check("mode after reset", {15'h0000, query_mode}, 16'h0000);
    check("drive after reset", {15'h0000, dq_oe}, 16'h0000);
    host_u.bus_read(21'h00_0027, rd);
    check("array word", rd, 16'h0027 ^ 16'h5a5a);
    host_u.bus_write(8'h50);
    check("mode after other code", {15'h0000, query_mode}, 16'h0000);
    host_u.bus_write(fqt_pkg::CMD_QUERY_ENTRY);
    check("mode after entry", {15'h0000, query_mode}, 16'h0001);
    foreach (tbl[i]) begin
      host_u.bus_read({13'h0000, tbl[i][15:8]}, rd);
      check("query word", rd, {8'h00, tbl[i][7:0]});
    end
    host_u.bus_read(21'h00_0050, rd);
    check("unlisted word", rd, 16'h0000);
    for (int b = 0; b < 32; b++) begin
      host_u.bus_read({b[4:0], 16'h0002}, rd);
      check("block status", rd, {15'h0000, block_protected[b]});
    end
    host_u.bus_write(fqt_pkg::CMD_READ_ARRAY);
    check("mode after exit", {15'h0000, query_mode}, 16'h0000);
    host_u.bus_read(21'h02_0002, rd);
    check("array after exit", rd, 16'h0002 ^ 16'h5a5a);
    complete_run();
  end
endmodule
